// >>> test/cms_core_model.sv
// behavioural analog comparator core behind the input mux and reference divider
`timescale 1ns/1ps
module cms_core_model (
    input  wire logic        enable,
    input  wire logic [1:0]  pos_sel,
    input  wire logic [1:0]  neg_sel,
    input  wire logic [7:0]  ref_code,
    input  wire logic [31:0] pos_lvls,
    input  wire logic [23:0] neg_lvls,
    output logic             raw_out
);
    // ------------------------------------------------------------
    // input levels and comparison
    // ------------------------------------------------------------
    logic [7:0] p_lvl;
    logic [7:0] n_lvl;
    assign p_lvl = pos_lvls[pos_sel*8 +: 8];
    // negative pin or divider, code/256 of a 256-step reference
    assign n_lvl = (neg_sel == 2'b11) ? ref_code : neg_lvls[neg_sel*8 +: 8];
    // an unpowered core drives low so no stale result leaks out
    assign raw_out = enable & (p_lvl > n_lvl);
endmodule

// >>> test/test_cms_ctrl.sv
// self-checking bench for the comparator mux and status control block
`timescale 1ns/1ps
module test_cms_ctrl;
    import cms_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, cmp_raw, irq;
    logic        cmp_enable, cmp_low_power, cmp_run_standby, negative_ref_selected;
    logic        cmp_event_out, pad_out, pad_oe;
    logic [1:0]  cmp_hysteresis, positive_input_select, negative_input_select;
    logic [7:0]  reference_level_code;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [31:0] seed = 32'd37;
    int          n_fail = 0, checks = 0;
    int          ctrl_m = 0, mux_m = 0, ref_m = 255, ie_m = 0, flag_m = 0;

    cms_ctrl uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cmp_raw, .cmp_enable, .cmp_low_power, .cmp_run_standby, .cmp_hysteresis,
        .positive_input_select, .negative_input_select, .negative_ref_selected,
        .reference_level_code, .cmp_event_out, .pad_out, .pad_oe, .irq);
    // pins sit at 0x20/0x60/0xa0/0xe0 and 0x50/0x90/0xd0 so every pairing is decisive
    cms_core_model core (.enable(cmp_enable), .pos_sel(positive_input_select),
        .neg_sel(negative_input_select), .ref_code(reference_level_code),
        .pos_lvls(32'he0a06020), .neg_lvls(24'hd09050), .raw_out(cmp_raw));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // reporting and bus tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            n_fail++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp,
                       input logic xerr);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0, r, e);
        chk(nm, exp, r);
        chk({nm, "_err"}, {31'h0, xerr}, {31'h0, e});
    endtask

    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    // raw core result for the modelled selects; a powered-down core reads low
    function automatic int exp_raw();
        int p, n;
        p = 32 + 64 * ((mux_m >> 3) & 3);
        n = ((mux_m & 3) == 3) ? ref_m : 80 + 64 * (mux_m & 3);
        return (ctrl_m & 1) ? int'(p > n) : 0;
    endfunction
    function automatic int exp_state();
        return (ctrl_m & 1) ? (exp_raw() ^ ((mux_m >> 7) & 1)) : 0;
    endfunction
    // level change counted in the selected edge mode
    function automatic int hit(input int a, input int b);
        int md;
        md = (ctrl_m >> 4) & 3;
        return (a != b) && (md == 0 || md == b + 2);
    endfunction
    // write through the model, then let sync, flag and irq settle; the invert bit acts
    // at once on the old synchronised result, so the level may pass a midpoint first
    task automatic put(input logic [7:0] idx, input int d);
        logic [31:0] r;
        logic        e;
        int          o, r0, mid;
        o = exp_state();
        r0 = exp_raw();
        case (idx)
            CMS_IDX_CTRL: ctrl_m = d & 8'hff;
            CMS_IDX_MUX: mux_m = d & CMS_MUX_WMASK;
            CMS_IDX_REF: ref_m = d & 8'hff;
            CMS_IDX_INTCTL: ie_m = d & CMS_INT_WMASK;
            default: if (d & 1) flag_m = 0;
        endcase
        mid = (ctrl_m & 1) ? (r0 ^ ((mux_m >> 7) & 1)) : 0;
        if ((ctrl_m & 1) && (hit(o, mid) || hit(mid, exp_state()))) flag_m = 1;
        apb(1'b1, idx, d, r, e);
        repeat (8) @(posedge clk);
    endtask
    task automatic chk_out();
        int s;
        s = exp_state();
        rdc("status", CMS_IDX_STATUS, (s << 4) | flag_m, 1'b0);
        chk("event", s, cmp_event_out);
        chk("pad", s, pad_out);
        chk("irq", flag_m & ie_m, irq);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, psel, penable, pwrite} = 4'b1000;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc("ctrl", CMS_IDX_CTRL, 32'h0, 1'b0);
        rdc("mux", CMS_IDX_MUX, 32'h0, 1'b0);
        rdc("ref", CMS_IDX_REF, 32'hff, 1'b0);
        rdc("intctl", CMS_IDX_INTCTL, 32'h0, 1'b0);
        rdc("unmapped", 8'h01, 32'h0, 1'b1);
        // random control, select and reference words
        v = xs() & 32'hff;
        put(CMS_IDX_CTRL, v);
        chk("ctl_ports", v & 32'hcf, {cmp_run_standby, pad_oe, 2'b00, cmp_low_power,
            cmp_hysteresis, cmp_enable});
        v = xs() & 32'hff;
        put(CMS_IDX_MUX, v);
        rdc("mux_rb", CMS_IDX_MUX, v & CMS_MUX_WMASK, 1'b0);
        v = xs() & 32'hff;
        put(CMS_IDX_REF, v);
        chk("ref_port", v, reference_level_code);
        chk_out();
        // every positive, negative and invert combination
        put(CMS_IDX_REF, 32'h80);
        put(CMS_IDX_CTRL, 32'h01);
        for (int i = 0; i < 32; i++) begin
            put(CMS_IDX_STATUS, 32'h01);
            put(CMS_IDX_MUX, {i[4], 2'b00, i[3:2], 1'b0, i[1:0]});
            v = mux_m;
            chk("sel", {v[4:3], v[1:0], v[1:0] == 2'b11}, {positive_input_select,
                negative_input_select, negative_ref_selected});
            chk_out();
        end
        // each edge mode and the reserved code, plain and inverted, interrupt enabled
        put(CMS_IDX_INTCTL, 32'h01);
        for (int k = 0; k < 8; k++) begin
            put(CMS_IDX_MUX, (k & 1) ? 32'h83 : 32'h03);
            put(CMS_IDX_REF, (k & 1) ? 32'h00 : 32'hff);
            put(CMS_IDX_CTRL, 32'h01 | ((((k >> 1) == 3) ? 1 : ((k >> 1) ? (k >> 1) + 1 : 0))
                << 4));
            put(CMS_IDX_STATUS, 32'h01);
            put(CMS_IDX_REF, (k & 1) ? 32'hff : 32'h00);
            chk_out();
            put(CMS_IDX_STATUS, 32'h00);
            chk_out();
            put(CMS_IDX_REF, (k & 1) ? 32'h00 : 32'hff);
            chk_out();
            put(CMS_IDX_STATUS, 32'h01);
            chk_out();
        end
        // switched off: level held low and no edges flagged
        put(CMS_IDX_CTRL, 32'h00);
        put(CMS_IDX_REF, 32'hff);
        put(CMS_IDX_REF, 32'h00);
        chk_out();
        end_sim();
    end
endmodule

// >>> verilog/cms_ctrl.sv
// comparator mux, reference code, status and interrupt control with apb access
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps

module cms_ctrl (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [cms_pkg::CMS_ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic                             cmp_raw,
    output logic                                  cmp_enable,
    output logic                                  cmp_low_power,
    output logic                                  cmp_run_standby,
    output logic      [1:0]                       cmp_hysteresis,
    output logic      [1:0]                       positive_input_select,
    output logic      [1:0]                       negative_input_select,
    output logic                                  negative_ref_selected,
    output logic      [7:0]                       reference_level_code,
    output logic                                  cmp_event_out,
    output logic                                  pad_out,
    output logic                                  pad_oe,
    output logic                                  irq
);
    import cms_pkg::*;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] mux_r;
    logic [7:0] ref_r;
    logic [7:0] intctl_r;
    logic       flag_r;
    logic       sync1_r;
    logic       sync2_r;
    logic       state_r;
    logic       prev_r;
    logic       en_d_r;
    logic [7:0] idx;
    logic       setup;
    logic       wr_acc;
    logic       mapped;
    logic       edge_hit;
    logic       flag_nxt;
    logic [7:0] status;
    logic [7:0] rd_nxt;

    assign idx    = paddr[9:2];
    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite;
    assign status = {3'b000, state_r, 3'b000, flag_r};

    // address decode, unmapped indices answer with an error
    always_comb begin
        mapped = 1'b1;
        rd_nxt = 8'h00;
        case (idx)
            CMS_IDX_CTRL:   rd_nxt = ctrl_r;
            CMS_IDX_MUX:    rd_nxt = mux_r;
            CMS_IDX_REF:    rd_nxt = ref_r;
            CMS_IDX_INTCTL: rd_nxt = intctl_r;
            CMS_IDX_STATUS: rd_nxt = status;
            default:        mapped = 1'b0;
        endcase
        if (paddr[CMS_ADDR_W-1:10] != '0) begin
            mapped = 1'b0;
            rd_nxt = 8'h00;
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait-free access cycle after each setup cycle
    // ------------------------------------------------------------
    // answer is registered so prdata, pready and pslverr come from flops
    always_ff @(posedge clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite) ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
        end
    end

    // control register: enable, hysteresis, low power, edges, pad, standby
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= CMS_CTRL_RST;
        end else if (wr_acc && mapped && idx == CMS_IDX_CTRL) begin
            ctrl_r <= pwdata[7:0];
        end
    end

    // input select register, unused bits 6:5 and 2 stay zero
    always_ff @(posedge clk) begin
        if (rst) begin
            mux_r <= CMS_MUX_RST;
        end else if (wr_acc && mapped && idx == CMS_IDX_MUX) begin
            mux_r <= pwdata[7:0] & CMS_MUX_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ref_r <= CMS_REF_RST;
        end else if (wr_acc && mapped && idx == CMS_IDX_REF) begin
            ref_r <= pwdata[7:0];
        end
    end

    // interrupt enable, masks only the irq output; the status flag sets regardless
    always_ff @(posedge clk) begin
        if (rst) begin
            intctl_r <= CMS_INTCTL_RST;
        end else if (wr_acc && mapped && idx == CMS_IDX_INTCTL) begin
            intctl_r <= pwdata[7:0] & CMS_INT_WMASK;
        end
    end

    // ------------------------------------------------------------
    // comparator level path
    // ------------------------------------------------------------
    // two-flop synchroniser; the raw result is asynchronous to clk
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= cmp_raw;
            sync2_r <= sync1_r;
        end
    end

    // inversion after the synchroniser; off comparator reads low
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= 1'b0;
            prev_r  <= 1'b0;
            en_d_r  <= 1'b0;
        end else begin
            state_r <= ctrl_r[CMS_CTRL_ENABLE] && (sync2_r ^ mux_r[CMS_MUX_INVERT]);
            prev_r  <= state_r;
            en_d_r  <= ctrl_r[CMS_CTRL_ENABLE];
        end
    end

    // edge select; the reserved code sets nothing
    // edges from the inverted synchronised level, only once enabled
    always_comb begin
        case (cms_edge_e'(ctrl_r[CMS_CTRL_EDG_LO +: 2]))
            CMS_EDGE_ANY:  edge_hit = state_r ^ prev_r;
            CMS_EDGE_FALL: edge_hit = prev_r && !state_r;
            CMS_EDGE_RISE: edge_hit = state_r && !prev_r;
            default:       edge_hit = 1'b0;
        endcase
        edge_hit = edge_hit && en_d_r && ctrl_r[CMS_CTRL_ENABLE];
    end

    // write one clears, a same-cycle edge wins
    always_comb begin
        flag_nxt = flag_r;
        if (wr_acc && mapped && idx == CMS_IDX_STATUS && pwdata[CMS_IRQ_BIT]) begin
            flag_nxt = 1'b0;
        end
        if (edge_hit) begin
            flag_nxt = 1'b1;
        end
    end

    // interrupt flag register
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs to the analog core, pad and event consumers
    // ------------------------------------------------------------
    // enable and analog settings, input selects
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_enable            <= 1'b0;
            cmp_low_power         <= 1'b0;
            cmp_run_standby       <= 1'b0;
            cmp_hysteresis        <= 2'b00;
            positive_input_select <= 2'b00;
            negative_input_select <= 2'b00;
            negative_ref_selected <= 1'b0;
            reference_level_code  <= CMS_REF_RST;
        end else begin
            cmp_enable            <= ctrl_r[CMS_CTRL_ENABLE];
            cmp_low_power         <= ctrl_r[CMS_CTRL_LPMODE];
            cmp_run_standby       <= ctrl_r[CMS_CTRL_RUNSTB];
            cmp_hysteresis        <= ctrl_r[CMS_CTRL_HYS_LO +: 2];
            positive_input_select <= mux_r[CMS_MUX_POS_LO +: 2];
            negative_input_select <= mux_r[CMS_MUX_NEG_LO +: 2];
            negative_ref_selected <= mux_r[CMS_MUX_NEG_LO +: 2] == CMS_NEG_REF;
            reference_level_code  <= ref_r;
        end
    end

    // one level feeds event and pad; pad driven when control bit 6 (pad output enable) is set
    // level interrupt while flag and enable both hold
    always_ff @(posedge clk) begin
        if (rst) begin
            cmp_event_out <= 1'b0;
            pad_out       <= 1'b0;
            pad_oe        <= 1'b0;
            irq           <= 1'b0;
        end else begin
            cmp_event_out <= state_r;
            pad_out       <= state_r;
            pad_oe        <= ctrl_r[CMS_CTRL_PAD_OUTPUT_ENABLE];
            irq           <= flag_r && intctl_r[CMS_IRQ_BIT];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    level_delay_a: assert property (
        (ctrl_r[CMS_CTRL_ENABLE] && $stable(ctrl_r) && $stable(mux_r)) [*3]
        |-> state_r == ($past(cmp_raw, 3) ^ mux_r[CMS_MUX_INVERT]))
        else $error("status level not the input three cycles back");

    invert_path_a: assert property (
        ##1 $past(ctrl_r[CMS_CTRL_ENABLE])
        |-> state_r == ($past(sync2_r) ^ $past(mux_r[CMS_MUX_INVERT])))
        else $error("output level ignores the invert bit");

    event_pad_a: assert property (
        ##1 (cmp_event_out == $past(state_r)) && (pad_out == cmp_event_out))
        else $error("event and pad outputs disagree with level");

    pos_sel_a: assert property (
        ##1 positive_input_select == $past(mux_r[4:3]))
        else $error("positive select not from bits 4:3");

    neg_ref_a: assert property (
        ##1 negative_ref_selected == ($past(mux_r[1:0]) == 2'b11))
        else $error("reference not chosen by negative code 3");

    ref_code_a: assert property (
        $rose(wr_acc) && idx == CMS_IDX_REF && mapped
        |=> ##1 reference_level_code == $past(pwdata[7:0], 2))
        else $error("reference code output not written value");

    flag_clear_a: assert property (
        wr_acc && mapped && idx == CMS_IDX_STATUS && pwdata[0] && !edge_hit
        |=> !flag_r)
        else $error("flag not cleared by writing one");

    flag_hold_a: assert property (
        wr_acc && mapped && idx == CMS_IDX_STATUS && !pwdata[0] && flag_r
        |=> flag_r)
        else $error("writing zero changed the flag");

    rise_set_a: assert property (
        ctrl_r[5:4] == 2'b11 && ctrl_r[0] && en_d_r && $rose(state_r) |=> flag_r)
        else $error("rising edge did not set the flag");

    rsvd_edge_a: assert property (
        ctrl_r[5:4] == 2'b01 && !flag_r |=> !flag_r)
        else $error("reserved edge code set the flag");

    irq_level_a: assert property (
        flag_r && intctl_r[0] |=> irq)
        else $error("interrupt missing while enabled and flagged");

    irq_drop_a: assert property (
        !intctl_r[0] |=> !irq)
        else $error("interrupt high while disabled");

    off_quiet_a: assert property (
        !ctrl_r[CMS_CTRL_ENABLE] |=> !state_r && !edge_hit)
        else $error("disabled comparator still active");

    pad_en_a: assert property (
        ##1 pad_oe == $past(ctrl_r[6]))
        else $error("pad enable not from control bit 6");

    set_wins_a: assert property (
        edge_hit |=> flag_r)
        else $error("edge lost against a clear");

    apb_answer_a: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    fall_set_a: assert property (
        ctrl_r[5:4] == 2'b10 && ctrl_r[0] && en_d_r && $fell(state_r) |=> flag_r)
        else $error("falling edge did not set the flag");

    any_set_a: assert property (
        ctrl_r[5:4] == 2'b00 && ctrl_r[0] && en_d_r && $changed(state_r) |=> flag_r)
        else $error("edge in both-edge mode did not set the flag");

    status_read_a: assert property (
        setup && !pwrite && mapped && idx == CMS_IDX_STATUS
        |=> prdata[7:0] == {3'b000, $past(state_r), 3'b000, $past(flag_r)})
        else $error("status read does not show level and flag");

    irq_clear_a: assert property (
        !flag_r |=> !irq)
        else $error("interrupt high without the flag");

    neg_sel_a: assert property (
        ##1 negative_input_select == $past(mux_r[1:0]))
        else $error("negative select not from bits 1:0");

    enable_out_a: assert property (
        ##1 cmp_enable == $past(ctrl_r[0]))
        else $error("comparator enable not from control bit 0");

    unmapped_err_a: assert property (
        setup && !mapped |=> pready && pslverr)
        else $error("unmapped access without an error answer");
endmodule

// >>> verilog/cms_pkg.sv
// constants and types for the comparator mux and status control block
package cms_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] CMS_IDX_CTRL   = 8'h00;
    localparam logic [7:0] CMS_IDX_MUX    = 8'h02;
    localparam logic [7:0] CMS_IDX_REF    = 8'h04;
    localparam logic [7:0] CMS_IDX_INTCTL = 8'h06;
    localparam logic [7:0] CMS_IDX_STATUS = 8'h07;
    localparam int         CMS_ADDR_W     = 12;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CMS_CTRL_ENABLE = 0;
    localparam int CMS_CTRL_HYS_LO = 1;
    localparam int CMS_CTRL_LPMODE = 3;
    localparam int CMS_CTRL_EDG_LO = 4;
    localparam int CMS_CTRL_PAD_OUTPUT_ENABLE  = 6;
    localparam int CMS_CTRL_RUNSTB = 7;
    localparam int CMS_MUX_NEG_LO  = 0;
    localparam int CMS_MUX_POS_LO  = 3;
    localparam int CMS_MUX_INVERT  = 7;
    localparam int CMS_IRQ_BIT     = 0;
    localparam int CMS_STATE_BIT   = 4;

    // ------------------------------------------------------------
    // reset values and masks of writable bits
    // ------------------------------------------------------------
    localparam logic [7:0] CMS_CTRL_RST   = 8'h00;
    localparam logic [7:0] CMS_MUX_RST    = 8'h00;
    localparam logic [7:0] CMS_REF_RST    = 8'hff;
    localparam logic [7:0] CMS_INTCTL_RST = 8'h00;
    localparam logic [7:0] CMS_MUX_WMASK  = 8'h9b;
    localparam logic [7:0] CMS_INT_WMASK  = 8'h01;

    // ------------------------------------------------------------
    // edge selection codes and negative input code for the reference
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMS_EDGE_ANY  = 2'b00,
        CMS_EDGE_RSVD = 2'b01,
        CMS_EDGE_FALL = 2'b10,
        CMS_EDGE_RISE = 2'b11
    } cms_edge_e;
    localparam logic [1:0] CMS_NEG_REF    = 2'b11;
    localparam int         CMS_STATE_DLY  = 3;
endpackage
